// >>> rtl/spt_config_regs.sv
// Serial-port reachable tuning, termination-calibration and checksum configuration bank.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Swing bit 0 selects normal (0) or high (1) sync swing; resets 0.
// - Rising edge of outer calibration bit starts PHY 0,1,6,7 calibration.
// - Rising edge of inner calibration bit starts PHY 2,3,4,5 calibration.
// - Checksum mode 0 uses the standard field sum; mode resets to 0.
// - Checksum mode 1 sums packed bytes 0x450 to 0x45A modulo 256.
// - The local checksum feeds all per-lane checksum compare registers.
module spt_config_regs (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic [8*spt_regs_pkg::PACKED_BYTES-1:0] link_packed_bytes,
	input wire logic [7:0] link_field_sum,
	output logic [7:0] lane_pll_pump_two_value,
	output logic [7:0] lane_pll_oscillator_one,
	output logic [7:0] lane_pll_oscillator_two,
	output logic [7:0] lane_pll_detector_two,
	output logic [7:0] lane_pll_varactor_two,
	output logic [7:0] lane_pll_pump_three_value,
	output logic [7:0] lane_pll_varactor_three,
	output logic [7:0] lane_pll_varactor_four,
	output logic [7:0] clock_setup_word,
	output logic [7:0] term_setup_word_a,
	output logic [7:0] term_setup_word_b,
	output logic [7:0] term_setup_word_c,
	output logic [7:0] term_setup_word_d,
	output logic sync_out_swing_select,
	output logic outer_term_cal_trigger,
	output logic inner_term_cal_trigger,
	output logic checksum_mode,
	output logic [7:0] lane_sum_compare_regs
);
	import spt_regs_pkg::*;

	// Byte sum wraps naturally in eight bits, which is the modulo 256 the link expects.
	function automatic logic [7:0] spt_byte_sum(input logic [8*PACKED_BYTES-1:0] bytes);
		logic [7:0] acc;
		acc = 8'h00;
		for (int i = 0; i < PACKED_BYTES; i++) begin
			acc = acc + bytes[8*i +: 8];
		end
		return acc;
	endfunction

	logic sclk_q;
	logic [4:0] bit_cnt;
	logic [14:0] instr_sh;
	logic [6:0] data_sh;
	logic [7:0] rd_sh;
	logic is_read;
	logic [14:0] addr;
	logic wr_en;
	logic [7:0] wr_data;
	logic outer_cal;
	logic inner_cal;
	logic outer_q;
	logic inner_q;
	logic [7:0] rd_value;
	logic [14:0] next_addr;
	logic sclk_rise;
	logic sclk_fall;

	// Pins are synchronous to ref_clk, so the serial clock is edge-detected directly.
	assign sclk_rise = !spi_cs_n && spi_sclk && !sclk_q;
	assign sclk_fall = !spi_cs_n && !spi_sclk && sclk_q;
	assign next_addr = {instr_sh[13:0], spi_sdi};

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= spi_sclk;
		end
	end

	// Frame: read flag, 15 address bits, 8 data bits, MSB first, sampled on rising edges.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt <= 5'h00;
			instr_sh <= 15'h0000;
			data_sh <= 7'h00;
			is_read <= 1'b0;
			addr <= 15'h0000;
			wr_en <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			wr_en <= 1'b0;
			if (spi_cs_n) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise) begin
				// Stopping one past the last bit keeps extra clocks from writing a second time.
				if (bit_cnt < 5'(FRAME_BITS)) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
				if (bit_cnt < 5'(INSTR_BITS - 1)) begin
					instr_sh <= next_addr;
				end else if (bit_cnt == 5'(INSTR_BITS - 1)) begin
					is_read <= instr_sh[14];
					addr <= next_addr;
				end else if (bit_cnt < 5'(FRAME_BITS - 1)) begin
					data_sh <= {data_sh[5:0], spi_sdi};
				end else if (bit_cnt == 5'(FRAME_BITS - 1) && !is_read) begin
					wr_en <= 1'b1;
					wr_data <= {data_sh, spi_sdi};
				end
			end
		end
	end

	always_comb begin
		unique case (addr)
			ADDR_PUMP_TWO: rd_value = lane_pll_pump_two_value;
			ADDR_OSC_ONE: rd_value = lane_pll_oscillator_one;
			ADDR_OSC_TWO: rd_value = lane_pll_oscillator_two;
			ADDR_DET_TWO: rd_value = lane_pll_detector_two;
			ADDR_VAR_TWO: rd_value = lane_pll_varactor_two;
			ADDR_PUMP_THREE: rd_value = lane_pll_pump_three_value;
			ADDR_VAR_THREE: rd_value = lane_pll_varactor_three;
			ADDR_VAR_FOUR: rd_value = lane_pll_varactor_four;
			ADDR_CLOCK_SETUP: rd_value = clock_setup_word;
			ADDR_TERM_A: rd_value = term_setup_word_a;
			ADDR_TERM_B: rd_value = term_setup_word_b;
			ADDR_TERM_C: rd_value = term_setup_word_c;
			ADDR_TERM_D: rd_value = term_setup_word_d;
			ADDR_SYNC_SWING: rd_value = 8'(sync_out_swing_select) << POS_SWING;
			ADDR_OUTER_CAL: rd_value = 8'(outer_cal) << POS_CAL;
			ADDR_INNER_CAL: rd_value = 8'(inner_cal) << POS_CAL;
			ADDR_RX_CTRL_ZERO: rd_value = 8'(checksum_mode) << POS_CKSUM_MODE;
			default: rd_value = 8'h00;
		endcase
	end

	// Read data leaves on falling edges so the host can sample it on the next rising edge.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_sh <= 8'h00;
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else begin
			if (spi_cs_n) begin
				spi_sdo_oe <= 1'b0;
			end else if (sclk_rise && bit_cnt == 5'(INSTR_BITS - 1)) begin
				rd_sh <= 8'h00;
			end else if (sclk_fall && bit_cnt == 5'(INSTR_BITS) && is_read) begin
				spi_sdo <= rd_value[7];
				rd_sh <= {rd_value[6:0], 1'b0};
				spi_sdo_oe <= 1'b1;
			end else if (sclk_fall && bit_cnt > 5'(INSTR_BITS) && is_read) begin
				spi_sdo <= rd_sh[7];
				rd_sh <= {rd_sh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lane_pll_pump_two_value <= RST_PUMP_TWO;
			lane_pll_oscillator_one <= RST_OSC_ONE;
			lane_pll_oscillator_two <= RST_OSC_TWO;
			lane_pll_detector_two <= RST_DET_TWO;
			lane_pll_varactor_two <= RST_VAR_TWO;
			lane_pll_pump_three_value <= RST_PUMP_THREE;
			lane_pll_varactor_three <= RST_VAR_THREE;
			lane_pll_varactor_four <= RST_VAR_FOUR;
			clock_setup_word <= RST_CLOCK_SETUP;
			term_setup_word_a <= RST_TERM_AC;
			term_setup_word_b <= RST_TERM_BD;
			term_setup_word_c <= RST_TERM_AC;
			term_setup_word_d <= RST_TERM_BD;
			sync_out_swing_select <= RST_BIT;
			outer_cal <= RST_BIT;
			inner_cal <= RST_BIT;
			checksum_mode <= RST_BIT;
		end else if (wr_en) begin
			unique case (addr)
				ADDR_PUMP_TWO: lane_pll_pump_two_value <= wr_data;
				ADDR_OSC_ONE: lane_pll_oscillator_one <= wr_data;
				ADDR_OSC_TWO: lane_pll_oscillator_two <= wr_data;
				ADDR_DET_TWO: lane_pll_detector_two <= wr_data;
				ADDR_VAR_TWO: lane_pll_varactor_two <= wr_data;
				ADDR_PUMP_THREE: lane_pll_pump_three_value <= wr_data;
				ADDR_VAR_THREE: lane_pll_varactor_three <= wr_data;
				ADDR_VAR_FOUR: lane_pll_varactor_four <= wr_data;
				ADDR_CLOCK_SETUP: clock_setup_word <= wr_data;
				ADDR_TERM_A: term_setup_word_a <= wr_data;
				ADDR_TERM_B: term_setup_word_b <= wr_data;
				ADDR_TERM_C: term_setup_word_c <= wr_data;
				ADDR_TERM_D: term_setup_word_d <= wr_data;
				ADDR_SYNC_SWING: sync_out_swing_select <= wr_data[POS_SWING];
				ADDR_OUTER_CAL: outer_cal <= wr_data[POS_CAL];
				ADDR_INNER_CAL: inner_cal <= wr_data[POS_CAL];
				ADDR_RX_CTRL_ZERO: checksum_mode <= wr_data[POS_CKSUM_MODE];
				default: ;
			endcase
		end
	end

	// Only a fresh edge calibrates; rewriting a one leaves the terminations alone.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			outer_q <= 1'b0;
			inner_q <= 1'b0;
			outer_term_cal_trigger <= 1'b0;
			inner_term_cal_trigger <= 1'b0;
		end else begin
			outer_q <= outer_cal;
			inner_q <= inner_cal;
			outer_term_cal_trigger <= outer_cal && !outer_q;
			inner_term_cal_trigger <= inner_cal && !inner_q;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lane_sum_compare_regs <= 8'h00;
		end else if (checksum_mode) begin
			lane_sum_compare_regs <= spt_byte_sum(link_packed_bytes);
		end else begin
			lane_sum_compare_regs <= link_field_sum;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	swing_follows_write_a: assert property (
		wr_en && addr == ADDR_SYNC_SWING |=> sync_out_swing_select == $past(wr_data[0]))
		else $error("swing select did not take written bit");
	outer_cal_edge_a: assert property ($rose(outer_cal) |=> outer_term_cal_trigger)
		else $error("outer calibration not started on rising edge");
	outer_cal_steady_a: assert property (
		outer_cal && $past(outer_cal) |=> !outer_term_cal_trigger)
		else $error("outer calibration started on steady level");
	inner_cal_edge_a: assert property (
		$rose(inner_cal) |=> inner_term_cal_trigger ##1 !inner_term_cal_trigger)
		else $error("inner calibration pulse wrong");
	field_sum_mode_a: assert property (
		!checksum_mode |=> lane_sum_compare_regs == $past(link_field_sum))
		else $error("field checksum not used in mode zero");
	packed_sum_mode_a: assert property (
		checksum_mode |=> lane_sum_compare_regs == $past(spt_byte_sum(link_packed_bytes)))
		else $error("packed byte checksum wrong in mode one");
	reserved_read_a: assert property (
		addr == ADDR_RX_CTRL_ZERO |-> (rd_value & 8'hBF) == 8'h00)
		else $error("reserved bits read nonzero");
	ignored_write_a: assert property (
		wr_en && addr == ADDR_SYNC_SWING && wr_data[0] == 1'b0
		|=> !sync_out_swing_select)
		else $error("swing bit set by reserved bits");

	write_seen_c: cover property (wr_en && addr == ADDR_PUMP_TWO);
	read_seen_c: cover property (is_read && spi_sdo_oe);
	both_cal_c: cover property (outer_term_cal_trigger ##[1:200] inner_term_cal_trigger);
	mode_flip_c: cover property ($rose(checksum_mode));
endmodule // spt_config_regs
`default_nettype wire

// >>> rtl/spt_regs_pkg.sv
// Register map, reset values and serial-port framing constants for the lane front-end bank.
package spt_regs_pkg;
	localparam int ADDR_W = 15;
	localparam int INSTR_BITS = 16;
	localparam int FRAME_BITS = 24;
	localparam int PACKED_BYTES = 11;
	localparam logic [14:0] ADDR_PUMP_TWO = 15'h0294;
	localparam logic [14:0] ADDR_OSC_ONE = 15'h0296;
	localparam logic [14:0] ADDR_OSC_TWO = 15'h0297;
	localparam logic [14:0] ADDR_DET_TWO = 15'h0299;
	localparam logic [14:0] ADDR_VAR_TWO = 15'h029A;
	localparam logic [14:0] ADDR_PUMP_THREE = 15'h029C;
	localparam logic [14:0] ADDR_VAR_THREE = 15'h029F;
	localparam logic [14:0] ADDR_VAR_FOUR = 15'h02A0;
	localparam logic [14:0] ADDR_CLOCK_SETUP = 15'h02A4;
	localparam logic [14:0] ADDR_SYNC_SWING = 15'h02A5;
	localparam logic [14:0] ADDR_OUTER_CAL = 15'h02A7;
	localparam logic [14:0] ADDR_TERM_A = 15'h02AA;
	localparam logic [14:0] ADDR_TERM_B = 15'h02AB;
	localparam logic [14:0] ADDR_INNER_CAL = 15'h02AE;
	localparam logic [14:0] ADDR_TERM_C = 15'h02B1;
	localparam logic [14:0] ADDR_TERM_D = 15'h02B2;
	localparam logic [14:0] ADDR_RX_CTRL_ZERO = 15'h0300;
	localparam logic [7:0] RST_PUMP_TWO = 8'hB0;
	localparam logic [7:0] RST_OSC_ONE = 8'h0C;
	localparam logic [7:0] RST_OSC_TWO = 8'h00;
	localparam logic [7:0] RST_DET_TWO = 8'h00;
	localparam logic [7:0] RST_VAR_TWO = 8'hFE;
	localparam logic [7:0] RST_PUMP_THREE = 8'h17;
	localparam logic [7:0] RST_VAR_THREE = 8'h33;
	localparam logic [7:0] RST_VAR_FOUR = 8'h08;
	localparam logic [7:0] RST_CLOCK_SETUP = 8'h4B;
	localparam logic [7:0] RST_TERM_AC = 8'hC3;
	localparam logic [7:0] RST_TERM_BD = 8'h93;
	localparam logic RST_BIT = 1'b0;
	localparam int POS_SWING = 0;
	localparam int POS_CAL = 0;
	localparam int POS_CKSUM_MODE = 6;
endpackage

// >>> testbench/spt_config_regs_test.sv
// Self-checking bench for the lane front-end configuration bank.
`timescale 1ns/1ps
`default_nettype none
module spt_config_regs_test;
	import spt_regs_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sclk = 1'b0;
	logic cs_n = 1'b1;
	logic sdi = 1'b0;
	logic [8*PACKED_BYTES-1:0] packed_bytes = '0;
	logic [7:0] field_sum = 8'h00;
	wire logic sdo, sdo_oe, swing, outer_cal, inner_cal, cks_mode;
	wire logic [7:0] lane_sum;
	wire logic [7:0] outs [13];
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int outer_n = 0;
	int inner_n = 0;
	logic [7:0] rd;
	logic [7:0] exp_sum;
	localparam logic [14:0] ADDRS [13] = '{ADDR_PUMP_TWO, ADDR_OSC_ONE, ADDR_OSC_TWO,
		ADDR_DET_TWO, ADDR_VAR_TWO, ADDR_PUMP_THREE, ADDR_VAR_THREE, ADDR_VAR_FOUR,
		ADDR_CLOCK_SETUP, ADDR_TERM_A, ADDR_TERM_B, ADDR_TERM_C, ADDR_TERM_D};
	localparam logic [7:0] RSTS [13] = '{8'hB0, 8'h0C, 8'h00, 8'h00, 8'hFE, 8'h17, 8'h33,
		8'h08, 8'h4B, 8'hC3, 8'h93, 8'hC3, 8'h93};
	localparam logic [7:0] GOOD [13] = '{8'h24, 8'h03, 8'h0D, 8'h02, 8'h8E, 8'h2A, 8'h78,
		8'h06, 8'hFF, 8'hB7, 8'h87, 8'hB7, 8'h87};
	spt_config_regs i_spt_config_regs (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.spi_sclk(sclk),
		.spi_cs_n(cs_n),
		.spi_sdi(sdi),
		.spi_sdo(sdo),
		.spi_sdo_oe(sdo_oe),
		.link_packed_bytes(packed_bytes),
		.link_field_sum(field_sum),
		.lane_pll_pump_two_value(outs[0]),
		.lane_pll_oscillator_one(outs[1]),
		.lane_pll_oscillator_two(outs[2]),
		.lane_pll_detector_two(outs[3]),
		.lane_pll_varactor_two(outs[4]),
		.lane_pll_pump_three_value(outs[5]),
		.lane_pll_varactor_three(outs[6]),
		.lane_pll_varactor_four(outs[7]),
		.clock_setup_word(outs[8]),
		.term_setup_word_a(outs[9]),
		.term_setup_word_b(outs[10]),
		.term_setup_word_c(outs[11]),
		.term_setup_word_d(outs[12]),
		.sync_out_swing_select(swing),
		.outer_term_cal_trigger(outer_cal),
		.inner_term_cal_trigger(inner_cal),
		.checksum_mode(cks_mode),
		.lane_sum_compare_regs(lane_sum)
	);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic results;
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Each serial clock level is held several ref_clk cycles, since the port samples it.
	task automatic frame(input logic rnw, input logic [14:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [23:0] word;
		word = {rnw, addr, wdata};
		rdata = 8'h00;
		@(negedge ref_clk);
		cs_n = 1'b0;
		for (int i = 0; i < 24; i++) begin
			sclk = 1'b0;
			sdi = word[23-i];
			repeat (3) @(negedge ref_clk);
			if (i >= 16) begin
				rdata = {rdata[6:0], sdo};
			end
			if (i == 23) begin
				check({7'h00, sdo_oe}, {7'h00, rnw});
			end
			sclk = 1'b1;
			repeat (2) @(negedge ref_clk);
		end
		sclk = 1'b0;
		repeat (3) @(negedge ref_clk);
		cs_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		check({7'h00, sdo_oe}, 8'h00);
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] unused;
		frame(1'b0, a, d, unused);
	endtask
	task automatic rdreg(input logic [14:0] a, output logic [7:0] d);
		frame(1'b1, a, 8'h00, d);
	endtask
	// Counting trigger cycles catches both a missing pulse and one that lasts too long.
	// Sampling on the falling edge keeps the count clear of the edge that launches a pulse.
	always @(negedge ref_clk) begin
		cycles <= cycles + 1;
		if (outer_cal === 1'b1) outer_n <= outer_n + 1;
		if (inner_cal === 1'b1) inner_n <= inner_n + 1;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (2) @(negedge ref_clk);
		for (int i = 0; i < 13; i++) begin
			check(outs[i], RSTS[i]);
			rdreg(ADDRS[i], rd);
			check(rd, RSTS[i]);
		end
		check({7'h00, swing}, 8'h00);
		check({7'h00, cks_mode}, 8'h00);
		field_sum = 8'h5A;
		@(negedge ref_clk);
		check(lane_sum, 8'h5A);
		for (int i = 0; i < 13; i++) begin
			wr(ADDRS[i], GOOD[i]);
			check(outs[i], GOOD[i]);
			rdreg(ADDRS[i], rd);
			check(rd, GOOD[i]);
		end
		wr(ADDR_SYNC_SWING, 8'hFF);
		rdreg(ADDR_SYNC_SWING, rd);
		check(rd, 8'h01);
		check({7'h00, swing}, 8'h01);
		wr(ADDR_SYNC_SWING, 8'hFE);
		check({7'h00, swing}, 8'h00);
		wr(ADDR_OUTER_CAL, 8'hFF);
		rdreg(ADDR_OUTER_CAL, rd);
		check(rd, 8'h01);
		wr(ADDR_OUTER_CAL, 8'h01);
		check(outer_n[7:0], 8'h01);
		check(inner_n[7:0], 8'h00);
		wr(ADDR_OUTER_CAL, 8'h00);
		wr(ADDR_OUTER_CAL, 8'h01);
		check(outer_n[7:0], 8'h02);
		wr(ADDR_INNER_CAL, 8'hFF);
		rdreg(ADDR_INNER_CAL, rd);
		check(rd, 8'h01);
		wr(ADDR_INNER_CAL, 8'h01);
		wr(ADDR_INNER_CAL, 8'h00);
		wr(ADDR_INNER_CAL, 8'h01);
		check(inner_n[7:0], 8'h02);
		check(outer_n[7:0], 8'h02);
		exp_sum = 8'h00;
		for (int i = 0; i < PACKED_BYTES; i++) begin
			packed_bytes[8*i +: 8] = 8'hE5 + 8'(13 * i);
			exp_sum = exp_sum + packed_bytes[8*i +: 8];
		end
		@(negedge ref_clk);
		check(lane_sum, 8'h5A);
		wr(ADDR_RX_CTRL_ZERO, 8'hFF);
		rdreg(ADDR_RX_CTRL_ZERO, rd);
		check(rd, 8'h40);
		check({7'h00, cks_mode}, 8'h01);
		check(lane_sum, exp_sum);
		wr(ADDR_RX_CTRL_ZERO, 8'h00);
		check(lane_sum, 8'h5A);
		wr(15'h0295, 8'hA5);
		rdreg(15'h0295, rd);
		check(rd, 8'h00);
		check(outs[0], 8'h24);
		resetn = 1'b0;
		@(negedge ref_clk);
		check(outs[0], RST_PUMP_TWO);
		resetn = 1'b1;
		repeat (2) @(negedge ref_clk);
		rdreg(ADDR_PUMP_TWO, rd);
		check(rd, RST_PUMP_TWO);
		check(outer_n[7:0], 8'h02);
		check(inner_n[7:0], 8'h02);
		check({7'h00, cks_mode}, 8'h00);
		results();
	end
endmodule // spt_config_regs_test
`default_nettype wire
